// ---- inc/xor_dir_cfg.svh ----
// Constants for the three-instruction decode and execute block
`ifndef XOR_DIR_CFG_SVH
`define XOR_DIR_CFG_SVH
`define OPC_DIRLOAD_MASK  14'h3FF8
`define OPC_DIRLOAD_VAL   14'h0060
`define OPC_XORLIT_MASK   14'h3F00
`define OPC_XORLIT_VAL    14'h3A00
`define OPC_XORFILE_MASK  14'h3F00
`define OPC_XORFILE_VAL   14'h0600
`define DIR_SEL_MIN       3'h5
`define DIR_SEL_MAX       3'h7
`define DIR_ADDR_BASE     7'h05
`define DIR_ADDR_TOP      7'h07
`define DIR_RESET         8'hFF
`define W_RESET           8'h00
`define DEST_BIT          7
`define FIELD_LSB         0
`define SEL_MSB           2
`define ADDR_MSB          6
`define LIT_MSB           7
`define ZERO_BYTE         8'h00
`endif

// ---- inc/xor_dir_pkg.sv ----
// Types shared by the decode and execute block
package xor_dir_pkg;
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
  typedef enum logic [1:0] {OP_NONE, OP_DIRLOAD, OP_XORLIT, OP_XORFILE} op_t;
  typedef struct packed {
    logic       wrEn;
    logic [6:0] addr;
    logic [7:0] data;
  } fileWr_t;
endpackage : xor_dir_pkg

// ---- logic/dir_reg_file.sv ----
// Three port direction registers, with a registered read port
`include "xor_dir_cfg.svh"
module dir_reg_file
  import xor_dir_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       wrEn,
  input  wire logic [1:0] wrIdx,
  input  wire logic [7:0] wrData,
  input  wire logic [1:0] rdIdx,
  output logic [7:0]      rdData_q,
  output logic [23:0]     dirAll_q
);
  logic [7:0] mem_q [3];

  // Storage, reset to all inputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 3; i++) begin
        mem_q[i] <= `DIR_RESET;
      end
    end else if (wrEn && wrIdx < 2'h3) begin
      mem_q[wrIdx] <= wrData;
    end
  end

  // Registered read and flat copy
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= `ZERO_BYTE;
      dirAll_q <= {3{`DIR_RESET}};
    end else begin
      rdData_q <= (rdIdx < 2'h3) ? mem_q[rdIdx] : `ZERO_BYTE;
      dirAll_q <= {mem_q[2], mem_q[1], mem_q[0]};
    end
  end
endmodule : dir_reg_file

// ---- logic/xor_dir_exec.sv ----
// Decode and execute of direction load and the two XOR instructions
`include "xor_dir_cfg.svh"
module xor_dir_exec
  import xor_dir_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [13:0] instrWord,
  input  wire logic [7:0]  fileRdData,
  output logic [6:0]       fileRdAddr_q,
  output fileWr_t          fileWr_q,
  output logic [7:0]       work_q,
  output logic             zero_q,
  output logic [23:0]      dirAll_q,
  output logic [1:0]       phase_q,
  output logic             instrDone_q
);
  phase_t     ph_q;
  op_t        op_q;
  logic [13:0] ir_q;
  logic [7:0] operand_q;
  logic [7:0] result_q;
  logic       isDir_q;
  logic [7:0] dirRd;
  logic [1:0] dirRdIdx;
  logic       dirWrEn;
  logic [1:0] dirWrIdx;
  logic [7:0] dirWrData;

  // Whether a file address hits a direction register
  function automatic logic isDirAddr(input logic [6:0] a);
    return (a >= `DIR_ADDR_BASE) && (a <= `DIR_ADDR_TOP);
  endfunction : isDirAddr

  function automatic logic [1:0] dirIdx(input logic [6:0] a);
    return 2'(a - `DIR_ADDR_BASE);
  endfunction : dirIdx

  // Register address field of a word
  function automatic logic [6:0] addrField(input logic [13:0] word);
    return word[`ADDR_MSB:`FIELD_LSB];
  endfunction : addrField

  // Literal field of a word
  function automatic logic [7:0] litField(input logic [13:0] word);
    return word[`LIT_MSB:`FIELD_LSB];
  endfunction : litField

  // Direction select field of a word
  function automatic logic [2:0] selField(input logic [13:0] word);
    return word[`SEL_MSB:`FIELD_LSB];
  endfunction : selField

  // Opcode classes; refused words fall to no operation
  function automatic op_t decodeOp(input logic [13:0] word);
    if ((word & `OPC_DIRLOAD_MASK) == `OPC_DIRLOAD_VAL &&
        selField(word) >= `DIR_SEL_MIN) begin
      return OP_DIRLOAD;
    end else if ((word & `OPC_XORLIT_MASK) == `OPC_XORLIT_VAL) begin
      return OP_XORLIT;
    end else if ((word & `OPC_XORFILE_MASK) == `OPC_XORFILE_VAL) begin
      return OP_XORFILE;
    end else begin
      return OP_NONE;
    end
  endfunction : decodeOp

  // Register XOR that sends its result back to the register
  function automatic logic toFile(input op_t op, input logic [13:0] word);
    return (op == OP_XORFILE) && word[`DEST_BIT];
  endfunction : toFile

  // Either XOR, the only instructions that touch the zero flag
  function automatic logic isXor(input op_t op);
    return (op == OP_XORLIT) || (op == OP_XORFILE);
  endfunction : isXor

  // Four-phase sequencer, one instruction per turn
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_q <= PH_Q1;
    end else begin
      case (ph_q)
        PH_Q1:   ph_q <= PH_Q2;
        PH_Q2:   ph_q <= PH_Q3;
        PH_Q3:   ph_q <= PH_Q4;
        PH_Q4:   ph_q <= PH_Q1;
        default: ph_q <= PH_Q1;
      endcase
    end
  end

  // Q1 decode: latch word and classify
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ir_q <= 14'h0000;
      op_q <= OP_NONE;
    end else if (ph_q == PH_Q1) begin
      ir_q <= instrWord;
      op_q <= decodeOp(instrWord);
    end
  end

  // Q1 end: operand address out, direction hit noted
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fileRdAddr_q <= 7'h00;
      isDir_q      <= 1'b0;
    end else if (ph_q == PH_Q1) begin
      fileRdAddr_q <= addrField(instrWord);
      isDir_q      <= isDirAddr(addrField(instrWord));
    end
  end

  // Q2 read: operand from literal, data memory or direction register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      operand_q <= `ZERO_BYTE;
    end else if (ph_q == PH_Q2) begin
      case (op_q)
        OP_XORLIT:  operand_q <= litField(ir_q);
        OP_XORFILE: operand_q <= isDir_q ? dirRd : fileRdData;
        default:    operand_q <= `ZERO_BYTE;
      endcase
    end
  end

  // Q3 process: the XOR itself
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_q <= `ZERO_BYTE;
    end else if (ph_q == PH_Q3) begin
      result_q <= work_q ^ operand_q;
    end
  end

  // Q4 write: result into W unless it goes back to the register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      work_q <= `W_RESET;
    end else if (ph_q == PH_Q4 && isXor(op_q) && !toFile(op_q, ir_q)) begin
      work_q <= result_q;
    end
  end

  // Q4 write: zero flag from either XOR, direction load leaves it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      zero_q <= 1'b0;
    end else if (ph_q == PH_Q4 && isXor(op_q)) begin
      zero_q <= (result_q == `ZERO_BYTE);
    end
  end

  // Q4 write: external data register, one-cycle strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fileWr_q <= '0;
    end else begin
      fileWr_q.wrEn <= (ph_q == PH_Q4) && toFile(op_q, ir_q) && !isDir_q;
      fileWr_q.addr <= addrField(ir_q);
      fileWr_q.data <= result_q;
    end
  end

  // Direction register writes: load instruction or addressed XOR
  always_comb begin
    dirWrEn   = 1'b0;
    dirWrIdx  = 2'h0;
    dirWrData = work_q;
    if (ph_q == PH_Q4) begin
      if (op_q == OP_DIRLOAD) begin
        dirWrEn  = 1'b1;
        dirWrIdx = 2'(selField(ir_q) - `DIR_SEL_MIN);
      end else if (toFile(op_q, ir_q) && isDir_q) begin
        dirWrEn   = 1'b1;
        dirWrIdx  = dirIdx(addrField(ir_q));
        dirWrData = result_q;
      end
    end
  end

  // Read index follows the word in decode, so Q2 sees current direction data
  assign dirRdIdx = dirIdx(addrField(instrWord));

  dir_reg_file u_dir (
    .clk      (clk),
    .arst_n   (arst_n),
    .wrEn     (dirWrEn),
    .wrIdx    (dirWrIdx),
    .wrData   (dirWrData),
    .rdIdx    (dirRdIdx),
    .rdData_q (dirRd),
    .dirAll_q (dirAll_q)
  );

  // Phase output, one cycle behind the sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= ph_q;
    end
  end

  // Completion pulse in the cycle after Q4
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      instrDone_q <= 1'b0;
    end else begin
      instrDone_q <= (ph_q == PH_Q4);
    end
  end
endmodule : xor_dir_exec

// ---- verification/file_mem.sv ----
// Data memory beside the decode and execute block
module file_mem
  import xor_dir_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [6:0] rdAddr,
  input  wire fileWr_t    wr,
  output logic [7:0]      rdData
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] m [128];
  // Seeded contents, mirrored by the bench
  initial for (int i = 0; i < 128; i++) m[i] = 8'(i * 37);
  // Operand read
  assign rdData = m[rdAddr];
  // Result write-back
  always @(posedge clk) if (wr.wrEn) m[wr.addr] <= wr.data;
endmodule : file_mem

// ---- verification/test_xor_dir_exec.sv ----
// Random instruction bench for the decode and execute block
module test_xor_dir_exec
  import xor_dir_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {fileWr_t wr; logic [7:0] w; logic z; logic [23:0] dir;} exp_t;
  logic clk, arst_n, zero_q, instrDone_q, z;
  logic [13:0] instrWord;
  logic [7:0] fileRdData, work_q, r, w, x;
  logic [6:0] fileRdAddr_q, f;
  logic [23:0] dirAll_q, dir;
  logic [1:0] phase_q;
  logic [7:0] sh [128];
  fileWr_t fileWr_q;
  exp_t q[$], e, n;
  int err_total, checks, cyc, k;
  xor_dir_exec u_xor_dir_exec (
    .clk          (clk),
    .arst_n       (arst_n),
    .instrWord    (instrWord),
    .fileRdData   (fileRdData),
    .fileRdAddr_q (fileRdAddr_q),
    .fileWr_q     (fileWr_q),
    .work_q       (work_q),
    .zero_q       (zero_q),
    .dirAll_q     (dirAll_q),
    .phase_q      (phase_q),
    .instrDone_q  (instrDone_q)
  );
  file_mem u_file_mem (.clk(clk), .rdAddr(fileRdAddr_q), .wr(fileWr_q), .rdData(fileRdData));
  // Compare and count
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    end
  endtask : chk
  // Verdict
  task automatic close_out;
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      close_out();
    end
  end
  // Result watcher
  always @(negedge clk) begin
    if (instrDone_q === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      chk(48'(fileWr_q.wrEn), 48'(e.wr.wrEn));
      chk(48'(phase_q), 48'(2'h3));
      if (e.wr.wrEn) chk(48'(fileWr_q), 48'(e.wr));
      @(negedge clk);
      chk(48'({work_q, zero_q, dirAll_q}), 48'({e.w, e.z, e.dir}));
    end
  end
  // Random instruction stream
  initial begin
    arst_n = 1'b0;
    instrWord = 14'h3FFF;
    w = 8'h00;
    z = 1'b0;
    dir = 24'hFFFFFF;
    for (int i = 0; i < 128; i++) sh[i] = 8'(i * 37);
    void'($urandom(32'h1B130A17));
    repeat (8) @(posedge clk);
    #2;
    for (int i = 0; i < 60; i++) begin
      k = $urandom % 5;
      r = 8'($urandom);
      f = r[7] ? 7'($urandom) : 7'(5 + $urandom % 3);
      n = '0;
      case (k)
        0: begin
          instrWord = 14'h0060 | 14'(r[2:0]);
          if (r[2:0] >= 5) dir[(r[2:0] - 5) * 8 +: 8] = w;
        end
        1, 2: begin
          x = (k == 2) ? w : r;
          instrWord = {6'h3A, x};
          w = w ^ x;
          z = (w == 8'h00);
        end
        3: begin
          instrWord = {6'h06, r[0], f};
          x = w ^ ((f inside {[5:7]}) ? dir[(f - 5) * 8 +: 8] : sh[f]);
          z = (x == 8'h00);
          if (!r[0]) w = x;
          else if (f inside {[5:7]}) dir[(f - 5) * 8 +: 8] = x;
          else begin
            sh[f] = x;
            n.wr = {1'b1, f, x};
          end
        end
        default: instrWord = 14'h3FFF;
      endcase
      n.w = w;
      n.z = z;
      n.dir = dir;
      q.push_back(n);
      arst_n = 1'b1;
      repeat (4) @(posedge clk);
      #2;
    end
    instrWord = 14'h3FFF;
    repeat (8) @(posedge clk);
    close_out();
  end
endmodule : test_xor_dir_exec

// ---- verification/xor_dir_exec_chk.sv ----
// Timing checker for the decode and execute block
module xor_dir_exec_chk
  import xor_dir_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [13:0] instrWord,
  input wire logic [7:0]  fileRdData,
  input wire logic [6:0]  fileRdAddr_q,
  input wire fileWr_t     fileWr_q,
  input wire logic [7:0]  work_q,
  input wire logic        zero_q,
  input wire logic [23:0] dirAll_q,
  input wire logic [1:0]  phase_q,
  input wire logic        instrDone_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Four-clock instruction cycle
  sequence s_gap;
    !instrDone_q [*3] ##1 instrDone_q;
  endsequence
  // Completion cadence and write-back
  a_done_spacing: assert property (instrDone_q |=> s_gap)
    else $error("done gap");
  a_wr_at_done: assert property (fileWr_q.wrEn |-> instrDone_q)
    else $error("late write");
  a_phase_done: assert property (instrDone_q == (phase_q == 2'h3))
    else $error("phase vs done");
  a_wr_not_dir: assert property (fileWr_q.wrEn |-> !(fileWr_q.addr inside {[5:7]}))
    else $error("dir write out");
  a_wr_keeps_w: assert property (fileWr_q.wrEn |-> $stable(work_q))
    else $error("W moved");
  // W and Z move only at completion, the direction copy one cycle after it
  a_w_at_done: assert property ($changed(work_q) |-> instrDone_q)
    else $error("W early");
  a_z_at_done: assert property ($changed(zero_q) |-> instrDone_q)
    else $error("Z early");
  a_z_from_w: assert property (instrDone_q && $changed(work_q) |-> zero_q == (work_q == 8'h00))
    else $error("Z vs W");
  a_z_from_f: assert property (fileWr_q.wrEn |-> zero_q == (fileWr_q.data == 8'h00))
    else $error("Z vs f");
  a_dir_at_done: assert property ($changed(dirAll_q) |-> instrDone_q || $past(instrDone_q))
    else $error("dir early");
endmodule : xor_dir_exec_chk

bind xor_dir_exec xor_dir_exec_chk u_chk (.*);
